// File: rtl/ssld_regs.vh
// How it works
// - checking acts only when motor is stepper
// - encoder mode: capture step and encoder references
// - each step: scale encoder, flag excess difference
// - sensor mode: latch steps on active edge
// - each revolution: flag step-count deviation over threshold
// - threshold is unsigned 8-bit motor steps
// - flags bit 0x01 enables position control
// - flags bit 0x02 selects revolution sensor
// - flags bit 0x04 raises alarm on mismatch
// - sensor active low; 0x08 makes high
// - 0x10 slip correction, encoder only, no alarm
// - read settings 0x70746367 answers 18 bytes
// - answer: cmd, threshold, flags, reserved, checksum
// - write settings answered with 4-byte echo
`ifndef SSLD_REGS_VH
`define SSLD_REGS_VH
`define SSLD_ADDR_THRESH    4'h0
`define SSLD_ADDR_FLAGS     4'h1
`define SSLD_ADDR_STATUS    4'h2
`define SSLD_ADDR_IRQ_STAT  4'h3
`define SSLD_ADDR_IRQ_MASK  4'h4
`define SSLD_ADDR_STEPS_REV 4'h5
`define SSLD_ADDR_CNTS_REV  4'h6
`define SSLD_ADDR_DEVIATION 4'h7
`define SSLD_ADDR_CMD       4'h8
`define SSLD_ADDR_FRAME     4'h9
`define SSLD_ADDR_FRM_IDX   4'ha
`define SSLD_F_ENABLE       0
`define SSLD_F_SOURCE       1
`define SSLD_F_ALARM        2
`define SSLD_F_INVERT       3
`define SSLD_F_CORRECT      4
`define SSLD_CMD_READ       32'h70746367
`define SSLD_CMD_WRITE      32'h70746373
`define SSLD_FRAME_LEN      5'h12
`define SSLD_ECHO_LEN       5'h04
`define SSLD_RST_THRESH     8'h00
`define SSLD_RST_FLAGS      8'h00
`define SSLD_RST_STEPS_REV  16'h00c8
`define SSLD_RST_CNTS_REV   16'h0400
`define SSLD_IRQ_ERR        0
`define SSLD_IRQ_CMD        1
`endif

// File: rtl/ssld_scale.v
`timescale 1ns/1ns
`default_nettype none
// combinational scaling: encoder delta to motor steps
module ssld_scale (
   input  wire signed [31:0] i_enc_delta,
   input  wire        [15:0] i_steps_per_rev,
   input  wire        [15:0] i_counts_per_rev,
   output wire signed [31:0] o_steps
);
   wire signed [48:0] prod;
   wire signed [48:0] quot;
   wire        [15:0] div;

   // divide by zero guarded to one; a zero divisor is a setup error
   assign div     = (i_counts_per_rev == 16'h0000) ? 16'h0001
                                                   : i_counts_per_rev;
   assign prod    = i_enc_delta * $signed({1'b0, i_steps_per_rev});
   assign quot    = prod / $signed({33'h0, div});
   assign o_steps = quot[31:0];
endmodule // ssld_scale
`default_nettype wire

// File: rtl/ssld_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ssld_regs.vh"
module ssld_top (
   input  wire        i_core_clk,
   input  wire        i_sys_rst,
   input  wire        i_motor_is_stepper,
   input  wire        i_step_pulse,
   input  wire        i_step_dir,
   input  wire [31:0] i_encoder_count,
   input  wire        i_rev_sensor,
   input  wire [3:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   output reg         o_mismatch_error,
   output reg         o_alarm,
   output reg         o_correct_pulse,
   output reg         o_correct_dir,
   output wire        o_irq
);
   reg         [7:0]  mismatch_threshold_r;
   reg         [7:0]  posctl_flags_r;
   reg         [15:0] steps_per_revolution_r;
   reg         [15:0] encoder_counts_per_turn_r;
   reg         [1:0]  irq_stat_r;
   reg         [1:0]  irq_mask_r;
   reg  signed [31:0] step_pos_r;
   reg  signed [31:0] step_ref_r;
   reg  signed [31:0] enc_ref_r;
   reg  signed [31:0] deviation_r;
   reg                armed_r;
   reg                sens_d_r;
   reg                have_rev_r;
   reg         [31:0] cmd_word_r;
   reg         [7:0]  frame_r [0:17];
   reg         [4:0]  frame_len_r;
   reg         [4:0]  frm_idx_r;
   reg         [15:0] csum_r;
   wire signed [31:0] enc_steps;
   wire signed [31:0] step_now;
   wire signed [31:0] step_delta;
   wire signed [31:0] enc_delta;
   wire signed [31:0] diff;
   wire        [31:0] abs_diff;
   wire               active;
   wire               enc_mode;
   wire               sens_level;
   wire               sens_edge;
   wire               enc_check;
   wire               rev_check;
   wire               excess;
   wire               arm;
   wire               wr_cmd;
   wire               set_err;
   wire               set_cmd;
   integer            k;
   integer            j;

   // magnitude helper; used for encoder and revolution deviation
   function [31:0] mag;
      input [31:0] v;
      begin
         mag = v[31] ? (~v + 32'h0000_0001) : v;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // mode decode
   assign active     = i_motor_is_stepper &
                       posctl_flags_r[`SSLD_F_ENABLE];
   assign enc_mode   = ~posctl_flags_r[`SSLD_F_SOURCE];
   // sensor active low unless inverted
   assign sens_level = i_rev_sensor ~^
                       posctl_flags_r[`SSLD_F_INVERT];
   assign sens_edge  = sens_level & ~sens_d_r;
   assign arm        = active & ~armed_r;
   assign wr_cmd     = i_wr & (i_addr == `SSLD_ADDR_CMD);

   ////////////////////////////////////////////////////////////////////
   // encoder path
   assign enc_delta  = i_encoder_count - enc_ref_r;
   // commanded position including a step taken this cycle, so a
   // perfectly tracking encoder never trips a zero threshold
   assign step_now   = ~i_step_pulse ? step_pos_r :
                       i_step_dir ? step_pos_r - 32'h0000_0001
                                  : step_pos_r + 32'h0000_0001;
   assign step_delta = step_now - step_ref_r;

   ssld_scale u_scale (
      .i_enc_delta      (enc_delta),
      .i_steps_per_rev  (steps_per_revolution_r),
      .i_counts_per_rev (encoder_counts_per_turn_r),
      .o_steps          (enc_steps)
   );

   // on revolution, deviation is steps moved minus one revolution
   assign diff = enc_mode ? (step_delta - enc_steps)
               : (mag(step_delta) -
                  $signed({16'h0000, steps_per_revolution_r}));
   assign abs_diff  = mag(diff);
   // unsigned 8-bit threshold compare
   assign excess    = abs_diff > {24'h0, mismatch_threshold_r};
   assign enc_check = active & armed_r & enc_mode & i_step_pulse;
   assign rev_check = active & armed_r & ~enc_mode & sens_edge &
                      have_rev_r;
   assign set_err   = (enc_check | rev_check) & excess;

   ////////////////////////////////////////////////////////////////////
   // step counting, references and error flag
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         step_pos_r       <= 32'h0000_0000;
         step_ref_r       <= 32'h0000_0000;
         enc_ref_r        <= 32'h0000_0000;
         deviation_r      <= 32'h0000_0000;
         armed_r          <= 1'b0;
         sens_d_r         <= 1'b0;
         have_rev_r       <= 1'b0;
         o_mismatch_error <= 1'b0;
         o_alarm          <= 1'b0;
         o_correct_pulse  <= 1'b0;
         o_correct_dir    <= 1'b0;
      end else begin
         sens_d_r        <= sens_level;
         o_correct_pulse <= 1'b0;
         if (i_step_pulse) begin
            step_pos_r <= step_now;
         end
         armed_r <= active;
         if (arm) begin
            // capture both references when control is armed
            step_ref_r       <= step_now;
            enc_ref_r        <= i_encoder_count;
            have_rev_r       <= 1'b0;
            o_mismatch_error <= 1'b0;
            o_alarm          <= 1'b0;
         end else if (active & ~enc_mode & sens_edge) begin
            // each active edge restarts the revolution count
            step_ref_r <= step_now;
            have_rev_r <= 1'b1;
            if (have_rev_r) begin
               deviation_r <= diff;
            end
         end else if (enc_check) begin
            deviation_r <= diff;
         end
         // set wins over software clear
         if (set_err) begin
            o_mismatch_error <= 1'b1;
            if (posctl_flags_r[`SSLD_F_ALARM]) begin
               o_alarm <= 1'b1;
            end
         end else if (i_wr & (i_addr == `SSLD_ADDR_STATUS) &
                      i_wdata[0]) begin
            o_mismatch_error <= 1'b0;
         end
         if (i_wr & (i_addr == `SSLD_ADDR_STATUS) & i_wdata[1] &
             ~set_err) begin
            o_alarm <= 1'b0;
         end
         // slip correction: encoder only and never with alarm
         if (set_err & enc_mode & posctl_flags_r[`SSLD_F_CORRECT] &
             ~posctl_flags_r[`SSLD_F_ALARM]) begin
            o_correct_pulse <= 1'b1;
            o_correct_dir   <= ~diff[31];
            step_ref_r      <= step_now - enc_steps;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // settings frame and command handling
   assign set_cmd = wr_cmd & ((i_wdata == `SSLD_CMD_READ) |
                              (i_wdata == `SSLD_CMD_WRITE));

   always @* begin
      csum_r = 16'h0000;
      for (j = 0; j < 16; j = j + 1) begin
         csum_r = csum_r + {8'h00, frame_r[j]};
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cmd_word_r  <= 32'h0000_0000;
         frame_len_r <= 5'h00;
         frm_idx_r   <= 5'h00;
         for (k = 0; k < 18; k = k + 1) begin
            frame_r[k] <= 8'h00;
         end
      end else begin
         if (i_rd & (i_addr == `SSLD_ADDR_FRAME) &
             (frm_idx_r < frame_len_r)) begin
            frm_idx_r <= frm_idx_r + 5'h01;
         end
         if (set_cmd) begin
            cmd_word_r <= i_wdata;
            frm_idx_r  <= 5'h00;
            frame_r[0] <= i_wdata[7:0];
            frame_r[1] <= i_wdata[15:8];
            frame_r[2] <= i_wdata[23:16];
            frame_r[3] <= i_wdata[31:24];
            if (i_wdata == `SSLD_CMD_READ) begin
               // full settings answer frame
               frame_len_r <= `SSLD_FRAME_LEN;
               frame_r[4]  <= mismatch_threshold_r;
               frame_r[5]  <= posctl_flags_r;
               for (k = 6; k < 16; k = k + 1) begin
                  frame_r[k] <= 8'h00;
               end
            end else begin
               // write settings: echo only
               frame_len_r <= `SSLD_ECHO_LEN;
            end
         end
         if (frame_len_r == `SSLD_FRAME_LEN) begin
            frame_r[16] <= csum_r[7:0];
            frame_r[17] <= csum_r[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register writes
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         mismatch_threshold_r      <= `SSLD_RST_THRESH;
         posctl_flags_r            <= `SSLD_RST_FLAGS;
         steps_per_revolution_r    <= `SSLD_RST_STEPS_REV;
         encoder_counts_per_turn_r <= `SSLD_RST_CNTS_REV;
         irq_mask_r                <= 2'b00;
      end else if (i_wr) begin
         if (i_addr == `SSLD_ADDR_THRESH) begin
            mismatch_threshold_r <= i_wdata[7:0];
         end else if (i_addr == `SSLD_ADDR_FLAGS) begin
            posctl_flags_r <= {3'b000, i_wdata[4:0]};
         end else if (i_addr == `SSLD_ADDR_IRQ_MASK) begin
            irq_mask_r <= i_wdata[1:0];
         end else if (i_addr == `SSLD_ADDR_STEPS_REV) begin
            steps_per_revolution_r <= i_wdata[15:0];
         end else if (i_addr == `SSLD_ADDR_CNTS_REV) begin
            encoder_counts_per_turn_r <= i_wdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt status: sticky, write one to clear, set wins
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         irq_stat_r <= 2'b00;
      end else begin
         irq_stat_r <= (irq_stat_r &
                        ~((i_wr & (i_addr == `SSLD_ADDR_IRQ_STAT)) ?
                          i_wdata[1:0] : 2'b00)) |
                       {set_cmd, set_err};
      end
   end

   assign o_irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe; zero otherwise
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         if (i_addr == `SSLD_ADDR_THRESH) begin
            o_rdata <= {24'h0, mismatch_threshold_r};
         end else if (i_addr == `SSLD_ADDR_FLAGS) begin
            o_rdata <= {24'h0, posctl_flags_r};
         end else if (i_addr == `SSLD_ADDR_STATUS) begin
            o_rdata <= {29'h0, armed_r, o_alarm, o_mismatch_error};
         end else if (i_addr == `SSLD_ADDR_IRQ_STAT) begin
            o_rdata <= {30'h0, irq_stat_r};
         end else if (i_addr == `SSLD_ADDR_IRQ_MASK) begin
            o_rdata <= {30'h0, irq_mask_r};
         end else if (i_addr == `SSLD_ADDR_STEPS_REV) begin
            o_rdata <= {16'h0, steps_per_revolution_r};
         end else if (i_addr == `SSLD_ADDR_CNTS_REV) begin
            o_rdata <= {16'h0, encoder_counts_per_turn_r};
         end else if (i_addr == `SSLD_ADDR_DEVIATION) begin
            o_rdata <= deviation_r;
         end else if (i_addr == `SSLD_ADDR_CMD) begin
            o_rdata <= cmd_word_r;
         end else if (i_addr == `SSLD_ADDR_FRAME) begin
            o_rdata <= (frm_idx_r < frame_len_r) ?
                       {24'h0, frame_r[frm_idx_r]} : 32'h0000_0000;
         end else if (i_addr == `SSLD_ADDR_FRM_IDX) begin
            o_rdata <= {27'h0, frm_idx_r};
         end else begin
            o_rdata <= 32'h0000_0000;
         end
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule // ssld_top
`default_nettype wire

// File: tb/ssld_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssld_regs.vh"
// watches the top ports only, attached by the bind below
module ssld_monitor (
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_motor_is_stepper,
   input wire logic        i_step_pulse,
   input wire logic        i_step_dir,
   input wire logic [31:0] i_encoder_count,
   input wire logic        i_rev_sensor,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_mismatch_error,
   input wire logic        o_alarm,
   input wire logic        o_correct_pulse,
   input wire logic        o_correct_dir,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////
   // read data only in the slot after the strobe
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside its slot");
   a_thresh_width: assert property ($past(i_rd) &&
      $past(i_addr) == `SSLD_ADDR_THRESH |-> o_rdata[31:8] == 24'h0)
      else $error("threshold wider than a byte");
   a_err_stepper: assert property ($rose(o_mismatch_error) |->
      $past(i_motor_is_stepper)) else $error("error without stepper");
   a_alarm_with_err: assert property ($rose(o_alarm) |-> o_mismatch_error)
      else $error("alarm without error");
   // arming may land one edge after the flags write
   a_err_sticky: assert property ($fell(o_mismatch_error) |->
      $past(i_wr) || $past(i_wr, 2)) else $error("error dropped alone");
   a_alarm_sticky: assert property ($fell(o_alarm) |->
      $past(i_wr) || $past(i_wr, 2)) else $error("alarm dropped alone");
   a_corr_on_step: assert property (o_correct_pulse |->
      $past(i_step_pulse)) else $error("correction without step");
   a_corr_no_alarm: assert property (o_correct_pulse |-> !$rose(o_alarm))
      else $error("correction raised alarm");
   ////////////////////////////////////////////////////////////////////
   c_error: cover property ($rose(o_mismatch_error));
   c_alarm: cover property ($rose(o_alarm));
   c_correct: cover property (o_correct_pulse);
endmodule // ssld_monitor
bind ssld_top ssld_monitor u_ssld_monitor (.*);
`default_nettype wire

// File: tb/ssld_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssld_regs.vh"
// host side: owns the register strobes, one cycle each
module ssld_host (
   input  wire logic        i_core_clk,
   input  wire logic [31:0] i_rdata,
   output var  logic [3:0]  o_addr,
   output var  logic [31:0] o_wdata,
   output var  logic        o_wr,
   output var  logic        o_rd
);
   // quiet bus from time zero
   initial begin
      o_addr = 4'h0;
      o_wdata = 32'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // strobe held for exactly one edge, then dropped
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge i_core_clk);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
      o_wdata <= ~v; // stale data must not be reused
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge i_core_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      #1 v = i_rdata;
   endtask
   // settings commands travel through the command word
   task automatic cmd(input logic [31:0] c);
      wr(`SSLD_ADDR_CMD, c);
   endtask
endmodule // ssld_host
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssld_regs.vh"
module tb_top;
   logic        clk, rst, stepper, step, dir, sens, wr, rd;
   logic        err, alarm, cpulse, cdir, irq, seen;
   logic [3:0]  addr;
   logic [31:0] enc, wdata, rdata, d;
   int          errors, checks;
   ////////////////////////////////////////////////////////////////////
   ssld_top u_ssld_top (.i_core_clk(clk), .i_sys_rst(rst),
      .i_motor_is_stepper(stepper), .i_step_pulse(step),
      .i_step_dir(dir), .i_encoder_count(enc), .i_rev_sensor(sens),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_mismatch_error(err), .o_alarm(alarm),
      .o_correct_pulse(cpulse), .o_correct_dir(cdir), .o_irq(irq));
   ssld_host u_ssld_host (.i_core_clk(clk), .i_rdata(rdata),
      .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   // 250 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a one-cycle correction pulse is easy to miss, so latch it
   always @(posedge clk) if (cpulse) seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      u_ssld_host.rd(a, d);
      chk(d === e, "register read");
   endtask
   // settle after the write edge before looking at outputs
   task automatic w(input logic [3:0] a, input logic [31:0] v);
      u_ssld_host.wr(a, v);
      #1;
   endtask
   // drop then raise enable so the references are taken again
   task automatic arm(input logic [31:0] f);
      w(`SSLD_ADDR_FLAGS, 32'h0);
      w(`SSLD_ADDR_FLAGS, f);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic steps(input int n, input logic [31:0] e);
      repeat (n) begin
         @(posedge clk);
         step <= 1'b1;
         enc <= enc + e;
         @(posedge clk);
         step <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic sn(input logic l);
      @(posedge clk);
      sens <= l;
      repeat (3) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rchk(`SSLD_ADDR_THRESH, {24'h0, `SSLD_RST_THRESH});
      rchk(`SSLD_ADDR_FLAGS, {24'h0, `SSLD_RST_FLAGS});
      rchk(`SSLD_ADDR_STEPS_REV, {16'h0, `SSLD_RST_STEPS_REV});
      rchk(4'hf, 32'h0);
   endtask
   // encoder offset nonzero at arming: references must be captured
   task automatic t_encoder();
      w(`SSLD_ADDR_CNTS_REV, 32'hc8);
      w(`SSLD_ADDR_THRESH, 32'h3);
      w(`SSLD_ADDR_IRQ_MASK, 32'h1);
      arm(32'h1);
      steps(20, 32'h1);
      steps(3, 32'h0);
      chk(err === 1'b0, "within threshold");
      steps(1, 32'h0);
      chk(err === 1'b1 && irq === 1'b1, "over threshold");
      rchk(`SSLD_ADDR_STATUS, 32'h5);
      w(`SSLD_ADDR_IRQ_STAT, 32'h1);
      chk(irq === 1'b0 && err === 1'b1, "irq clear");
      w(`SSLD_ADDR_STATUS, 32'h1);
      chk(err === 1'b0, "error clear");
   endtask
   task automatic t_alarm();
      w(`SSLD_ADDR_IRQ_MASK, 32'h0);
      arm(32'h5);
      steps(4, 32'h0);
      chk(alarm === 1'b1 && irq === 1'b0, "alarm masked");
      w(`SSLD_ADDR_IRQ_STAT, 32'h1);
      arm(32'h11);
      chk(alarm === 1'b0 && err === 1'b0, "rearm");
      seen = 1'b0;
      steps(4, 32'h0);
      chk(seen === 1'b1 && alarm === 1'b0, "correction");
      chk(cdir === 1'b1, "correction direction");
   endtask
   // active level equals inv; idle is its inverse, so a wrong
   // polarity measures the first revolution as 150 steps, a quarter turn short
   task automatic t_sensor(input logic inv);
      @(posedge clk);
      sens <= ~inv;
      arm(inv ? 32'hb : 32'h3);
      sn(inv);
      steps(150, 32'h0);
      sn(~inv);
      steps(50, 32'h0);
      sn(inv);
      steps(100, 32'h0);
      sn(~inv);
      chk(err === 1'b0, "full revolution");
      steps(90, 32'h0);
      sn(inv);
      chk(err === 1'b1, "short revolution");
      rchk(`SSLD_ADDR_DEVIATION, 32'hffff_fff6);
   endtask
   // the error left by the sensor run is cleared first
   task automatic t_not_stepper();
      w(`SSLD_ADDR_STATUS, 32'h3);
      chk(err === 1'b0, "cleared before");
      @(posedge clk);
      stepper <= 1'b0;
      arm(32'h1);
      steps(5, 32'h0);
      chk(err === 1'b0, "not a stepper");
      @(posedge clk);
      stepper <= 1'b1;
   endtask
   task automatic t_frames();
      logic [7:0]  b [18];
      logic [15:0] s;
      logic [31:0] c;
      b = '{default: 8'h0};
      c = `SSLD_CMD_READ;
      {b[3], b[2], b[1], b[0]} = c;
      b[4] = 8'h03;
      b[5] = 8'h05;
      s = 16'h0;
      for (int i = 0; i < 16; i++) s = s + b[i];
      {b[17], b[16]} = s;
      w(`SSLD_ADDR_FLAGS, 32'he5);
      u_ssld_host.cmd(c);
      repeat (2) @(posedge clk);
      for (int i = 0; i < 18; i++) begin
         u_ssld_host.rd(`SSLD_ADDR_FRAME, d);
         chk(d[7:0] === b[i], "settings frame");
      end
      c = `SSLD_CMD_WRITE;
      u_ssld_host.cmd(c);
      for (int i = 0; i < 4; i++) begin
         u_ssld_host.rd(`SSLD_ADDR_FRAME, d);
         chk(d[7:0] === c[8*i +: 8], "echo");
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // cuts a hang short; the run needs under 5000 cycles
   initial begin
      #100000;
      errors++;
      $display("mismatch %0t watchdog", $time);
      summarize();
   end
   initial begin
      {rst, stepper, sens} = 3'b111;
      {step, dir, seen, errors, checks} = '0;
      enc = 32'h100;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_encoder();
      t_alarm();
      t_sensor(1'b0);
      t_sensor(1'b1);
      t_not_stepper();
      t_frames();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
